// >>> design/hbmfa_pkg.sv
// Package with types and constants for the host bus master block.
package hbmfa_pkg;
    localparam int HBMFA_ADDR_W = 32;
    localparam int HBMFA_DATA_W = 32;
    localparam int HBMFA_BEAT_W = 4;
    localparam int HBMFA_FAST_ARB_BIT = 1;
    localparam logic [HBMFA_BEAT_W-1:0] HBMFA_LINE_BEATS = 4'h4;
    localparam logic [HBMFA_BEAT_W-1:0] HBMFA_ONE_BEAT = 4'h1;
    localparam logic [HBMFA_ADDR_W-1:0] HBMFA_WORD_STEP = 32'h0000_0004;
    localparam logic [1:0] HBMFA_SIZE_WORD = 2'h0;
    localparam logic [1:0] HBMFA_SIZE_LINE = 2'h3;

    // Master sequencer states.
    typedef enum logic [2:0] {
        HBMFA_IDLE  = 3'b000,
        HBMFA_REQ   = 3'b001,
        HBMFA_ARB   = 3'b010,
        HBMFA_START = 3'b011,
        HBMFA_WAIT  = 3'b100,
        HBMFA_DONE  = 3'b101
    } hbmfa_state_type;

    // One transfer request from the internal engine.
    typedef struct packed {
        logic write;
        logic fetch;
        logic [1:0] snoop;
        logic [2:0] modifier;
        logic [1:0] ttype;
        logic [HBMFA_ADDR_W-1:0] addr;
        logic [HBMFA_DATA_W-1:0] wdata;
        logic burst;
    } hbmfa_req_type;

    // Cycle attribute lines driven on the bus.
    typedef struct packed {
        logic rd_wr_n;
        logic [1:0] snoop_ctl;
        logic [2:0] xfer_modifier;
        logic [1:0] xfer_type;
    } hbmfa_attr_type;
endpackage

// >>> design/hbmfa_resp.sv
// Response decoder for the slave acknowledge lines.
`timescale 1ns/1ps
module hbmfa_resp
    import hbmfa_pkg::*;
(
    // Sampling qualifier.
    input wire logic active,
    // Bus answer lines.
    input wire logic xfer_ack_n,
    input wire logic xfer_err_ack_n,
    input wire logic burst_inhibit_n,
    // Decoded outcomes.
    output logic good,
    output logic retry,
    output logic fault,
    output logic inhibit
);
    // Outcomes count only while a master cycle is waiting.
    always_comb begin
        good = active && !xfer_ack_n && xfer_err_ack_n;
        retry = active && !xfer_ack_n && !xfer_err_ack_n;
        fault = active && xfer_ack_n && !xfer_err_ack_n;
        inhibit = active && !burst_inhibit_n;
    end
endmodule

// >>> design/hbmfa_master.sv
// Host bus master with fast arbitration, bursting, retry and fault.
`timescale 1ns/1ps
module hbmfa_master
    import hbmfa_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Configuration.
    input wire logic [7:0] dma_control_reg,
    // Internal engine request.
    input wire logic req_valid,
    input wire hbmfa_req_type req,
    output logic req_ready,
    output logic done,
    output logic [HBMFA_DATA_W-1:0] rdata,
    output logic rdata_valid,
    // Fault reporting.
    output logic bus_fault,
    input wire logic fault_clear,
    output logic irq,
    // Arbitration pins.
    output logic bus_req_n,
    input wire logic bus_grant_n,
    input wire logic bus_busy_n_in,
    output logic bus_busy_n,
    output logic bus_busy_oe,
    output logic master_n,
    output logic fetch_n,
    // Transfer control pins.
    output logic xfer_start_n,
    output logic xfer_in_progress_n,
    output logic ctl_oe,
    output hbmfa_attr_type attr,
    output logic [HBMFA_ADDR_W-1:0] addr,
    output logic [1:0] xfer_size,
    output logic addr_oe,
    output logic [HBMFA_DATA_W-1:0] wdata,
    output logic data_oe,
    input wire logic [HBMFA_DATA_W-1:0] rdata_in,
    // Slave answer pins.
    input wire logic xfer_ack_n,
    input wire logic xfer_err_ack_n,
    input wire logic burst_inhibit_n
);
    hbmfa_state_type state, next_state;
    hbmfa_req_type cur, next_cur;
    logic [HBMFA_BEAT_W-1:0] beats, next_beats;
    logic owned, next_owned;
    logic fault_flag, next_fault_flag;
    logic fetch_hold, next_fetch_hold;
    logic [HBMFA_DATA_W-1:0] next_rdata;
    logic next_rdata_valid, next_done;
    logic good, retry, fault, inhibit;
    logic fast_en, grant, own_now, waiting;

    // Fast mode flag decode from the control register.
    function automatic logic fast_bit(input logic [7:0] r);
        return r[HBMFA_FAST_ARB_BIT];
    endfunction

    assign fast_en = fast_bit(dma_control_reg);
    assign grant = !bus_grant_n;
    assign waiting = (state == HBMFA_WAIT);

    // Answer decoding, qualified by the waiting state.
    hbmfa_resp hbmfa_resp_inst (
        .active(waiting),
        .xfer_ack_n(xfer_ack_n),
        .xfer_err_ack_n(xfer_err_ack_n),
        .burst_inhibit_n(burst_inhibit_n),
        .good(good),
        .retry(retry),
        .fault(fault),
        .inhibit(inhibit)
    );

    // Ownership in fast mode follows grant combinationally while requesting.
    assign own_now = owned ||
        (state == HBMFA_REQ && fast_en && grant);

    // Next-state and datapath computation for the sequencer.
    always_comb begin
        next_state = state;
        next_cur = cur;
        next_beats = beats;
        next_owned = owned;
        next_fault_flag = fault_flag || fault;
        next_fetch_hold = fetch_hold;
        next_rdata = rdata;
        next_rdata_valid = 1'b0;
        next_done = 1'b0;
        if (fault_clear && !fault) begin
            next_fault_flag = 1'b0;
        end
        case (state)
            HBMFA_IDLE: begin
                if (req_valid) begin
                    next_cur = req;
                    next_beats = req.burst ? HBMFA_LINE_BEATS : HBMFA_ONE_BEAT;
                    next_fetch_hold = req.fetch;
                    next_state = HBMFA_REQ;
                end
            end
            HBMFA_REQ: begin
                if (fast_en && grant) begin
                    next_owned = 1'b1;
                    next_state = HBMFA_START;
                end else if (!fast_en && grant && bus_busy_n_in) begin
                    next_state = HBMFA_ARB;
                end
            end
            HBMFA_ARB: begin
                next_owned = 1'b1;
                next_state = HBMFA_START;
            end
            HBMFA_START: begin
                next_state = HBMFA_WAIT;
            end
            HBMFA_WAIT: begin
                if (inhibit && beats != HBMFA_ONE_BEAT) begin
                    next_cur.burst = 1'b0;
                end
                if (retry) begin
                    next_state = HBMFA_START;
                end else if (fault) begin
                    next_owned = 1'b0;
                    next_fetch_hold = 1'b0;
                    next_state = HBMFA_DONE;
                end else if (good) begin
                    next_rdata = rdata_in;
                    next_rdata_valid = !cur.write;
                    if (beats == HBMFA_ONE_BEAT) begin
                        next_owned = 1'b0;
                        next_fetch_hold = 1'b0;
                        next_state = HBMFA_DONE;
                    end else begin
                        next_beats = beats - HBMFA_ONE_BEAT;
                        next_cur.addr = cur.addr + HBMFA_WORD_STEP;
                        next_state = HBMFA_START;
                    end
                end
            end
            HBMFA_DONE: begin
                next_done = 1'b1;
                next_state = HBMFA_IDLE;
            end
            default: begin
                next_state = HBMFA_IDLE;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= HBMFA_IDLE;
            cur <= '0;
            beats <= '0;
            owned <= 1'b0;
            fault_flag <= 1'b0;
            fetch_hold <= 1'b0;
            rdata <= '0;
            rdata_valid <= 1'b0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            cur <= next_cur;
            beats <= next_beats;
            owned <= next_owned;
            fault_flag <= next_fault_flag;
            fetch_hold <= next_fetch_hold;
            rdata <= next_rdata;
            rdata_valid <= next_rdata_valid;
            done <= next_done;
        end
    end

    // Arbitration pins; the fast path reacts to grant without a clock.
    always_comb begin
        bus_req_n = !(state == HBMFA_REQ && !own_now);
        bus_busy_n = !own_now;
        bus_busy_oe = own_now;
        master_n = !own_now;
        fetch_n = !(fetch_hold && state != HBMFA_IDLE);
    end

    // Bus cycle pins: attributes and address are enabled in the same cycle as start.
    always_comb begin
        ctl_oe = owned;
        attr.rd_wr_n = !cur.write;
        attr.snoop_ctl = cur.snoop;
        attr.xfer_modifier = cur.modifier;
        attr.xfer_type = cur.ttype;
        xfer_in_progress_n = !owned;
        xfer_start_n = !(state == HBMFA_START);
        addr = cur.addr;
        xfer_size = cur.burst ? HBMFA_SIZE_LINE : HBMFA_SIZE_WORD;
        addr_oe = owned;
        wdata = cur.wdata;
        data_oe = owned && cur.write;
        req_ready = (state == HBMFA_IDLE);
        bus_fault = fault_flag;
        irq = fault_flag;
    end

    // Checks on the sequencer.
    AST_START_ONE: assert property (
        @(posedge sys_clk) disable iff (rst)
        !xfer_start_n |=> xfer_start_n)
        else $error("Transfer start held longer than one clock.");
    AST_START_TIP: assert property (
        @(posedge sys_clk) disable iff (rst)
        !xfer_start_n |-> !xfer_in_progress_n && ctl_oe && addr_oe)
        else $error("Transfer start without in-progress or address.");
    AST_WR_DATA: assert property (
        @(posedge sys_clk) disable iff (rst)
        (!xfer_start_n && cur.write) |-> data_oe)
        else $error("Write start without data driven.");
    AST_FAST_OWN: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == HBMFA_REQ && fast_en && grant) |->
        (!master_n && !bus_busy_n && bus_req_n) ##1 !xfer_start_n)
        else $error("Fast grant did not take ownership.");
    AST_RETRY: assert property (
        @(posedge sys_clk) disable iff (rst)
        retry |=> !xfer_start_n && !fetch_n == $past(fetch_hold))
        else $error("Retry did not restart the cycle.");
    AST_FAULT: assert property (
        @(posedge sys_clk) disable iff (rst)
        fault |=> bus_fault && irq && master_n)
        else $error("Fault not reported or bus not released.");
    AST_LAST: assert property (
        @(posedge sys_clk) disable iff (rst)
        (good && beats == HBMFA_ONE_BEAT) |=>
        master_n && bus_busy_n && xfer_in_progress_n && !addr_oe)
        else $error("Last ack did not release the bus.");
    AST_MORE: assert property (
        @(posedge sys_clk) disable iff (rst)
        (good && beats != HBMFA_ONE_BEAT) |=>
        !xfer_start_n && !xfer_in_progress_n)
        else $error("Continuing beat did not restart.");
    AST_NO_DATA: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == HBMFA_IDLE) |-> !data_oe && !ctl_oe)
        else $error("Bus lines driven while idle.");
    AST_SLOW: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == HBMFA_REQ && !fast_en) |-> master_n)
        else $error("Ownership taken without fast mode handshake.");
    AST_REQ_LOW: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == HBMFA_REQ && !grant) |-> !bus_req_n && master_n)
        else $error("Bus request not asserted while waiting for grant.");
    AST_OWN_HELD: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == HBMFA_START) |-> !master_n && !bus_busy_n)
        else $error("Start issued without bus ownership.");
    AST_FETCH_LOW: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == HBMFA_START && cur.fetch) |-> !fetch_n)
        else $error("Fetch indicator high during a fetch cycle.");
    AST_FETCH_RETRY: assert property (
        @(posedge sys_clk) disable iff (rst)
        (retry && cur.fetch) |=> !fetch_n)
        else $error("Fetch indicator dropped during a retry.");
    AST_RETRY_ADDR: assert property (
        @(posedge sys_clk) disable iff (rst)
        retry |=> $stable(addr))
        else $error("Retry changed the beat address.");
    AST_ADDR_STEP: assert property (
        @(posedge sys_clk) disable iff (rst)
        (good && beats != HBMFA_ONE_BEAT) |=>
        addr == $past(addr) + HBMFA_WORD_STEP)
        else $error("Next beat address did not advance one word.");
    AST_INHIBIT: assert property (
        @(posedge sys_clk) disable iff (rst)
        (good && inhibit && beats != HBMFA_ONE_BEAT) |=>
        xfer_size == HBMFA_SIZE_WORD)
        else $error("Inhibited burst kept the line size.");
    AST_BURST_ON: assert property (
        @(posedge sys_clk) disable iff (rst)
        (good && !inhibit && cur.burst && beats != HBMFA_ONE_BEAT) |=>
        xfer_size == HBMFA_SIZE_LINE)
        else $error("Uninhibited burst lost the line size.");
    AST_HOLD_DATA: assert property (
        @(posedge sys_clk) disable iff (rst)
        !waiting |=> $stable(rdata))
        else $error("Read data captured outside a waiting cycle.");
    AST_RELEASE: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == HBMFA_DONE) |-> !addr_oe && !data_oe && !ctl_oe)
        else $error("Bus lines still driven after the last beat.");

    COV_FAST: cover property (@(posedge sys_clk) disable iff (rst)
        state == HBMFA_REQ && fast_en && grant);
    COV_BURST: cover property (@(posedge sys_clk) disable iff (rst)
        good ##1 !xfer_start_n ##1 good);
    COV_RETRY: cover property (@(posedge sys_clk) disable iff (rst) retry);
    COV_FAULT: cover property (@(posedge sys_clk) disable iff (rst) fault);
    COV_INHIBIT: cover property (@(posedge sys_clk) disable iff (rst)
        good && inhibit);
endmodule

// >>> dv/hbmfa_slave_model.sv
// Model of the host bus arbiter and the addressed slave.
`timescale 1ns/1ps
module hbmfa_slave_model
    import hbmfa_pkg::*;
(
    // Clock and master lines.
    input wire logic sys_clk,
    input wire logic bus_req_n,
    input wire logic xfer_start_n,
    input wire logic [HBMFA_ADDR_W-1:0] addr,
    // Answer style chosen by the bench.
    input wire logic [1:0] lat,
    input wire logic retry,
    input wire logic fault,
    input wire logic inhibit,
    // Arbiter and slave answers.
    output logic bus_grant_n,
    output logic xfer_ack_n,
    output logic xfer_err_ack_n,
    output logic burst_inhibit_n,
    output logic [HBMFA_DATA_W-1:0] rdata_in
);
    logic [HBMFA_ADDR_W-1:0] cur;
    logic [1:0] cnt;
    logic pend;
    // Everything starts released.
    initial begin
        {bus_grant_n, xfer_ack_n, xfer_err_ack_n, burst_inhibit_n} = 4'hf;
        rdata_in = 32'h0;
        pend = 1'b0;
        cnt = 2'h0;
    end
    // Grant follows the request, so it is a pulse once ownership drops it.
    always @(negedge sys_clk) begin
        bus_grant_n <= bus_req_n;
    end
    // Answer each start after lat idle cycles, for one cycle.
    always @(negedge sys_clk) begin
        {xfer_ack_n, xfer_err_ack_n, burst_inhibit_n} <= 3'h7;
        rdata_in <= ~rdata_in;
        if (!xfer_start_n) begin
            pend <= 1'b1;
            cnt <= lat;
            cur <= addr;
        end else if (pend && cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
        end else if (pend) begin
            pend <= 1'b0;
            xfer_ack_n <= fault;
            xfer_err_ack_n <= !(fault || retry);
            burst_inhibit_n <= !inhibit;
            rdata_in <= cur ^ 32'ha5a5_0000;
        end
    end
endmodule

// >>> dv/hbmfa_master_test.sv
// Self-checking bench for the host bus master block.
`timescale 1ns/1ps
module hbmfa_master_test;
    import hbmfa_pkg::*;
    logic sys_clk, rst, req_valid, req_ready, done, rdata_valid;
    logic bus_fault, fault_clear, irq, bus_req_n, bus_grant_n;
    logic bus_busy_n_in, bus_busy_n, bus_busy_oe, master_n, fetch_n;
    logic xfer_start_n, xfer_in_progress_n, ctl_oe, addr_oe, data_oe;
    logic xfer_ack_n, xfer_err_ack_n, burst_inhibit_n;
    logic retry, fault, inhibit, ts_d;
    logic [1:0] lat, xfer_size;
    logic [7:0] dma_control_reg;
    logic [31:0] rdata, addr, wdata, rdata_in;
    hbmfa_req_type req, rq;
    hbmfa_attr_type attr;
    logic [31:0] sa[$];
    logic [1:0] ss[$];
    int fail_count, n_compared, nv;

    hbmfa_master hbmfa_master_inst (.sys_clk, .rst, .dma_control_reg,
        .req_valid, .req, .req_ready, .done, .rdata, .rdata_valid,
        .bus_fault, .fault_clear, .irq, .bus_req_n, .bus_grant_n,
        .bus_busy_n_in, .bus_busy_n, .bus_busy_oe, .master_n, .fetch_n,
        .xfer_start_n, .xfer_in_progress_n, .ctl_oe, .attr, .addr,
        .xfer_size, .addr_oe, .wdata, .data_oe, .rdata_in, .xfer_ack_n,
        .xfer_err_ack_n, .burst_inhibit_n);
    hbmfa_slave_model hbmfa_slave_model_inst (.sys_clk, .bus_req_n,
        .xfer_start_n, .addr, .lat, .retry, .fault, .inhibit, .bus_grant_n,
        .xfer_ack_n, .xfer_err_ack_n, .burst_inhibit_n, .rdata_in);

    // Free-running 10 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input string n, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    function automatic hbmfa_req_type mk(logic w, f, b, logic [31:0] a);
        return '{w, f, 2'h2, 3'h5, 2'h1, a, ~a, b};
    endfunction

    // Record each start and check the lines that go with it.
    always @(posedge sys_clk) begin
        if (!rst && xfer_start_n === 1'b0) begin
            sa.push_back(addr);
            ss.push_back(xfer_size);
            chk("ts_width", ts_d, 1);
            chk("tip", xfer_in_progress_n, 0);
            chk("oe", {ctl_oe, addr_oe, data_oe}, {2'h3, rq.write});
            chk("attr", attr,
                {!rq.write, rq.snoop, rq.modifier, rq.ttype});
            chk("fetch", fetch_n, !rq.fetch);
            if (rq.write) chk("wdata", wdata, rq.wdata);
        end
        if (!rst) chk("busy", bus_busy_n, master_n);
        if (!rst && rdata_valid === 1'b1) nv++;
        ts_d <= xfer_start_n;
    end

    // Fast ownership follows the grant edge at once; start comes next.
    always @(negedge bus_grant_n) begin
        if (dma_control_reg[HBMFA_FAST_ARB_BIT]) begin
            #1;
            chk("own", {master_n, bus_busy_n, bus_req_n, bus_busy_oe},
                4'h3);
            @(negedge sys_clk);
            chk("first_start", xfer_start_n, 0);
        end
    end

    // The slave retries once; the repeated beat is then accepted.
    always @(negedge sys_clk) begin
        if (xfer_ack_n === 1'b0 && xfer_err_ack_n === 1'b0) retry <= 1'b0;
    end

    // Issue one request and wait for its end, then check the release.
    task automatic run(input hbmfa_req_type r, input int n);
        int k;
        rq = r;
        sa.delete();
        ss.delete();
        nv = 0;
        req <= r;
        req_valid <= 1'b1;
        @(negedge sys_clk);
        req_valid <= 1'b0;
        for (k = 0; k < 300 && done !== 1'b1; k++) @(negedge sys_clk);
        if (k == 300) begin
            chk("timeout", 0, 1);
            end_sim();
        end
        chk("starts", sa.size(), n);
        chk("release", {ctl_oe, addr_oe, data_oe, master_n,
            xfer_in_progress_n, bus_busy_oe, req_ready},
            7'h0d);
        @(negedge sys_clk);
    endtask

    task automatic s_read();
        bus_busy_n_in = 1'b0;
        run(mk(0, 1, 0, 32'h0000_1000), 1);
        bus_busy_n_in = 1'b1;
        chk("nvalid", nv, 1);
        chk("addr", sa[0], 32'h0000_1000);
        chk("size", ss[0], HBMFA_SIZE_WORD);
        chk("rdata", rdata, 32'ha5a5_1000);
    endtask

    task automatic s_burst_write();
        lat = 2'h0;
        run(mk(1, 0, 1, 32'h0000_2000), 4);
        foreach (sa[i]) chk("baddr", sa[i], 32'h2000 + 4 * i);
        chk("bsize", ss[3], HBMFA_SIZE_LINE);
        chk("nwvalid", nv, 0);
    endtask

    task automatic s_inhibit();
        inhibit = 1'b1;
        run(mk(0, 0, 1, 32'h0000_3000), 4);
        inhibit = 1'b0;
        chk("isize0", ss[0], HBMFA_SIZE_LINE);
        chk("isize1", ss[1], HBMFA_SIZE_WORD);
        chk("nivalid", nv, 4);
    endtask

    task automatic s_retry();
        retry = 1'b1;
        run(mk(0, 1, 0, 32'h0000_4000), 2);
        chk("raddr", sa[1], 32'h0000_4000);
        chk("rfetch", fetch_n, 1);
        chk("nrvalid", nv, 1);
    endtask

    task automatic s_fault();
        fault = 1'b1;
        run(mk(0, 1, 1, 32'h0000_5000), 1);
        fault = 1'b0;
        chk("fault", {bus_fault, irq}, 2'h3);
        fault_clear = 1'b1;
        @(negedge sys_clk);
        fault_clear = 1'b0;
        chk("fclr", bus_fault, 0);
    endtask

    task automatic s_normal();
        dma_control_reg = 8'h00;
        bus_busy_n_in = 1'b0;
        fork
            run(mk(1, 0, 0, 32'h0000_6000), 1);
            begin
                repeat (6) @(negedge sys_clk);
                chk("wait_busy", master_n, 1);
                chk("req", bus_req_n, 0);
                bus_busy_n_in = 1'b1;
            end
        join
        dma_control_reg = 8'h02;
    endtask

    // Reset for 8 cycles, then run every scenario.
    initial begin
        {rst, req_valid, fault_clear, retry, fault, inhibit} = 6'h20;
        lat = 2'h1;
        dma_control_reg = 8'h02;
        bus_busy_n_in = 1'b1;
        req = '0;
        rq = '0;
        ts_d = 1'b1;
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        s_read();
        s_burst_write();
        s_inhibit();
        s_retry();
        s_fault();
        s_normal();
        end_sim();
    end
endmodule
